// ===== common/sew_pkg.sv
// Behaviour
// - array is 512 pages of 128 bytes, reached by a 16-bit word address
// - data changes only while clock low; a change while clock high is start or stop
// - data falling while clock high starts a new command
// - data rising while clock high is a stop and returns to standby
// - 8-bit words; device pulls data low on the ninth clock as acknowledge
// - standby at power-up and after stop once internal work is done
// - next three address bits compare against the chip select straps
// - an unconnected chip select strap reads as low
// - last address bit high selects read, low selects write
// - matching address is acknowledged; mismatch is not and returns to standby
// - write protect high blocks writes to the whole array
// - write acknowledges address, both word-address bytes and each data byte
// - inputs ignored during programming; programming ends within 3 ms
// - page write increments low seven address bits, upper bits fixed, wrapping
// - more than 128 data bytes wrap and overwrite earlier bytes
// - ID page write uses type 1011b, B10 zero, B5..B0 pick the byte
// - locked ID page withholds acknowledge on every data byte
// - polling address is acknowledged only once programming has finished
// - data sampled on clock rising edge, driven on clock falling edge
// - lock command: type 1011b, B10 one, data bit 1 set; locks ID page
`default_nettype none
package sew_pkg;
   localparam int          PAGE_COUNT    = 512;
   localparam int          PAGE_BYTES    = 128;
   localparam int          WORD_ADDR_W   = 16;
   localparam int          ROW_W         = 9;
   localparam int          OFS_W         = 7;
   localparam int          ID_OFS_W      = 6;
   localparam int          BYTE_W        = 8;
   localparam int          CS_W          = 3;
   localparam int          IDSEL_BIT     = 2;
   localparam int          LOCK_DATA_BIT = 1;
   localparam logic [3:0]  TYPE_ARRAY    = 4'hA;
   localparam logic [3:0]  TYPE_IDPAGE   = 4'hB;
   localparam logic [3:0]  BIT_LAST      = 4'h7;
   localparam logic [3:0]  BIT_ACK       = 4'h8;
   localparam logic        RW_READ       = 1'b1;
   localparam logic        RST_STANDBY   = 1'b1;
   localparam logic        LINE_IDLE     = 1'b1;
   localparam int          CLK_MHZ       = 50;
   localparam int          PROG_TIME_US  = 3000;
   localparam int          PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_DEV,
      ST_ADDR_HI,
      ST_ADDR_LO,
      ST_DATA,
      ST_IGNORE
   } sew_fsm_type;
endpackage : sew_pkg
`default_nettype wire

// ===== design/sew_eeprom_write_port.sv
`timescale 1ns/1ps
`default_nettype none
module sew_eeprom_write_port #(
   parameter int PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
   // system
   input  wire logic                               mclk_i,
   input  wire logic                               rst_i,
   // two-wire link
   input  wire logic                               scl_i,
   input  wire logic                               sda_i,
   output wire logic                               sda_o,
   output wire logic                               sda_oe_o,
   // straps
   input  wire logic [sew_pkg::CS_W-1:0]           chip_select_straps_i,
   input  wire logic                               wp_i,
   // nonvolatile array port
   output wire logic                               nvm_wr_o,
   output wire logic                               nvm_id_o,
   output wire logic [sew_pkg::WORD_ADDR_W-1:0]    nvm_addr_o,
   output wire logic [sew_pkg::BYTE_W-1:0]         nvm_data_o,
   // status
   output wire logic                               busy_o,
   output wire logic                               standby_o,
   output wire logic                               id_locked_o
);

   localparam int TMR_W = $clog2(PROG_CYCLES + 1);
   localparam int ROW_W = sew_pkg::ROW_W;
   localparam int OFS_W = sew_pkg::OFS_W;
   localparam int BYTE_W = sew_pkg::BYTE_W;
   localparam int CS_W = sew_pkg::CS_W;
   localparam int PB = sew_pkg::PAGE_BYTES;
   localparam logic [OFS_W:0] WALK_END = (OFS_W + 1)'(PB);

   // ******************************************
   // state
   // ******************************************
   typedef struct packed {
      logic                          scl_m;
      logic                          scl_s;
      logic                          scl_p;
      logic                          sda_m;
      logic                          sda_s;
      logic                          sda_p;
      logic                          wp_m;
      logic                          wp_s;
      logic [CS_W-1:0]               cs_m;
      logic [CS_W-1:0]               cs_s;
      sew_pkg::sew_fsm_type          fsm;
      logic [3:0]                    bit_cnt;
      logic [BYTE_W-1:0]             shift;
      logic [BYTE_W-1:0]             hi;
      logic                          is_id;
      logic [ROW_W-1:0]              row;
      logic [OFS_W-1:0]              ofs;
      logic                          got_data;
      logic                          lock_req;
      logic [PB-1:0][BYTE_W-1:0]     buf_data;
      logic [PB-1:0]                 buf_vld;
      logic                          ack_req;
      logic                          busy;
      logic [TMR_W-1:0]              tmr;
      logic                          prog_id;
      logic                          prog_lock;
      logic [OFS_W:0]                walk;
      logic                          id_locked;
      logic                          nvm_wr;
      logic                          nvm_id;
      logic [sew_pkg::WORD_ADDR_W-1:0] nvm_addr;
      logic [BYTE_W-1:0]             nvm_data;
      logic                          standby;
   } sew_core_type;

   typedef struct packed {
      logic rst_m;
      logic rst_s;
      logic req_m;
      logic drive;
   } sew_link_type;

   sew_core_type      r;
   sew_core_type      next_r;
   sew_link_type      l;
   sew_link_type      next_l;
   logic              scl_rise;
   logic              start_evt;
   logic              stop_evt;
   logic [BYTE_W-1:0] shift_new;
   logic              match_now;
   logic              match_new;
   logic [OFS_W-1:0]  walk_idx;

   // ******************************************
   // core logic on the system clock
   // ******************************************
   always_comb begin
      next_r = r;
      next_r.scl_m = scl_i;
      next_r.scl_s = r.scl_m;
      next_r.scl_p = r.scl_s;
      next_r.sda_m = sda_i;
      next_r.sda_s = r.sda_m;
      next_r.sda_p = r.sda_s;
      next_r.wp_m = wp_i;
      next_r.wp_s = r.wp_m;
      next_r.cs_m = chip_select_straps_i;
      next_r.cs_s = r.cs_m;
      next_r.nvm_wr = 1'b0;
      // data sampled at the rising clock edge
      scl_rise = r.scl_s & ~r.scl_p;
      // edges of data with clock held high
      start_evt = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
      stop_evt = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
      shift_new = {r.shift[BYTE_W-2:0], r.sda_s};
      // type pattern and straps; pads pull floating straps low
      match_new = ((shift_new[7:4] == sew_pkg::TYPE_ARRAY) || (shift_new[7:4] == sew_pkg::TYPE_IDPAGE))
                  && (shift_new[3:1] == r.cs_s);
      match_now = 1'b0;
      walk_idx = r.walk[OFS_W-1:0];

      // self-timed programming: drain the page buffer then wait out the timer
      if (r.busy) begin
         if (r.walk < WALK_END) begin
            if (!r.prog_lock && r.buf_vld[walk_idx]) begin
               next_r.nvm_wr = 1'b1;
               next_r.nvm_id = r.prog_id;
               next_r.nvm_addr = r.prog_id ? {{ROW_W{1'b0}}, walk_idx} : {r.row, walk_idx};
               next_r.nvm_data = r.buf_data[walk_idx];
            end
            next_r.walk = r.walk + 1'b1;
         end
         if (r.tmr == '0) begin
            next_r.busy = 1'b0;
            if (r.prog_lock) begin
               next_r.id_locked = 1'b1;
            end
         end else begin
            next_r.tmr = r.tmr - 1'b1;
         end
      end

      if (start_evt) begin
         // any start, also the one closing bus recovery, opens a command
         next_r.fsm = sew_pkg::ST_DEV;
         next_r.bit_cnt = 4'h0;
         next_r.got_data = 1'b0;
         next_r.lock_req = 1'b0;
      end else if (stop_evt) begin
         // the clock that carries the stop has already counted one bit
         if ((r.fsm == sew_pkg::ST_DATA) && r.got_data && (r.bit_cnt == 4'h1) && !r.busy && !r.wp_s) begin
            next_r.busy = 1'b1;
            next_r.tmr = TMR_W'(PROG_CYCLES - 1);
            next_r.walk = '0;
            next_r.prog_id = r.is_id;
            next_r.prog_lock = r.lock_req;
         end
         next_r.fsm = sew_pkg::ST_STANDBY;
         next_r.bit_cnt = 4'h0;
      end else if (scl_rise && (r.fsm != sew_pkg::ST_STANDBY) && (r.fsm != sew_pkg::ST_IGNORE)) begin
         if (r.bit_cnt == sew_pkg::BIT_ACK) begin
            next_r.bit_cnt = 4'h0;
         end else begin
            next_r.shift = shift_new;
            next_r.bit_cnt = r.bit_cnt + 4'h1;
         end
         if (r.bit_cnt == sew_pkg::BIT_LAST) begin
            case (r.fsm)
               sew_pkg::ST_DEV: begin
                  if (match_new && !r.busy) begin
                     next_r.is_id = (shift_new[7:4] == sew_pkg::TYPE_IDPAGE);
                     if (shift_new[0] == sew_pkg::RW_READ) begin
                        next_r.fsm = sew_pkg::ST_IGNORE;
                     end else begin
                        next_r.fsm = sew_pkg::ST_ADDR_HI;
                        next_r.buf_vld = '0;
                     end
                  end else begin
                     next_r.fsm = sew_pkg::ST_STANDBY;
                  end
               end
               sew_pkg::ST_ADDR_HI: begin
                  next_r.hi = shift_new;
                  next_r.fsm = sew_pkg::ST_ADDR_LO;
               end
               sew_pkg::ST_ADDR_LO: begin
                  next_r.row = {r.hi, shift_new[BYTE_W-1]};
                  // identification page uses the low six bits only
                  next_r.ofs = r.is_id ? {1'b0, shift_new[sew_pkg::ID_OFS_W-1:0]} : shift_new[OFS_W-1:0];
                  next_r.fsm = sew_pkg::ST_DATA;
               end
               sew_pkg::ST_DATA: begin
                  if (r.is_id && r.id_locked) begin
                     next_r.fsm = sew_pkg::ST_IGNORE;
                  end else begin
                     if (r.is_id && r.hi[sew_pkg::IDSEL_BIT]) begin
                        if (shift_new[sew_pkg::LOCK_DATA_BIT]) begin
                           next_r.lock_req = 1'b1;
                        end
                     end else begin
                        next_r.buf_data[r.ofs] = shift_new;
                        next_r.buf_vld[r.ofs] = 1'b1;
                     end
                     // low seven bits count and wrap inside the page
                     next_r.ofs = r.ofs + 1'b1;
                     next_r.got_data = 1'b1;
                  end
               end
               default: begin
                  next_r.fsm = sew_pkg::ST_STANDBY;
               end
            endcase
         end
      end

      // acknowledge request spans the eighth bit so the link stage drives the ninth
      match_now = ((next_r.shift[6:3] == sew_pkg::TYPE_ARRAY) || (next_r.shift[6:3] == sew_pkg::TYPE_IDPAGE))
                  && (next_r.shift[2:0] == r.cs_s);
      next_r.ack_req = 1'b0;
      if (next_r.bit_cnt == sew_pkg::BIT_LAST) begin
         case (next_r.fsm)
            sew_pkg::ST_DEV: begin
               next_r.ack_req = match_now && !r.busy;
            end
            sew_pkg::ST_ADDR_HI: begin
               next_r.ack_req = 1'b1;
            end
            sew_pkg::ST_ADDR_LO: begin
               next_r.ack_req = 1'b1;
            end
            sew_pkg::ST_DATA: begin
               next_r.ack_req = !(next_r.is_id && next_r.id_locked);
            end
            default: begin
               next_r.ack_req = 1'b0;
            end
         endcase
      end
      next_r.standby = (next_r.fsm == sew_pkg::ST_STANDBY) && !next_r.busy;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         r <= '0;
         r.fsm <= sew_pkg::ST_STANDBY;
         r.standby <= sew_pkg::RST_STANDBY;
         // sync stages start at the idle line level, no false edge after reset
         r.scl_m <= sew_pkg::LINE_IDLE;
         r.scl_s <= sew_pkg::LINE_IDLE;
         r.scl_p <= sew_pkg::LINE_IDLE;
         r.sda_m <= sew_pkg::LINE_IDLE;
         r.sda_s <= sew_pkg::LINE_IDLE;
         r.sda_p <= sew_pkg::LINE_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // ******************************************
   // link stage on the serial clock
   // ******************************************
   always_comb begin
      next_l = l;
      next_l.rst_m = rst_i;
      next_l.rst_s = l.rst_m;
      next_l.req_m = r.ack_req & ~l.rst_s;
      // pull low from the falling edge that opens the ninth clock
      next_l.drive = l.req_m & ~l.rst_s;
   end

   always_ff @(negedge scl_i) begin
      l <= next_l;
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = l.drive;
   assign nvm_wr_o = r.nvm_wr;
   assign nvm_id_o = r.nvm_id;
   assign nvm_addr_o = r.nvm_addr;
   assign nvm_data_o = r.nvm_data;
   assign busy_o = r.busy;
   assign standby_o = r.standby;
   assign id_locked_o = r.id_locked;

   // ******************************************
   // assertions
   // ******************************************
   property p_start_cmd;
      @(posedge mclk_i) disable iff (rst_i)
      start_evt |=> (r.fsm == sew_pkg::ST_DEV) && (r.bit_cnt == 4'h0);
   endproperty
   a_start_cmd: assert property (p_start_cmd) else $error("start did not open a command");

   property p_stop_idle;
      @(posedge mclk_i) disable iff (rst_i)
      (stop_evt && !start_evt) |=> (r.fsm == sew_pkg::ST_STANDBY);
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to standby");

   property p_ack_slot;
      @(posedge mclk_i) disable iff (rst_i)
      r.ack_req |-> (r.bit_cnt == sew_pkg::BIT_LAST) && (r.fsm != sew_pkg::ST_STANDBY)
                    && (r.fsm != sew_pkg::ST_IGNORE);
   endproperty
   a_ack_slot: assert property (p_ack_slot) else $error("acknowledge outside its slot");

   property p_mismatch;
      @(posedge mclk_i) disable iff (rst_i)
      (scl_rise && !start_evt && !stop_evt && (r.fsm == sew_pkg::ST_DEV) && (r.bit_cnt == sew_pkg::BIT_LAST)
       && !match_new) |=> (r.fsm == sew_pkg::ST_STANDBY);
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("foreign address not dropped");

   property p_busy_silent;
      @(posedge mclk_i) disable iff (rst_i)
      (r.busy && (r.fsm == sew_pkg::ST_DEV)) |-> !r.ack_req;
   endproperty
   a_busy_silent: assert property (p_busy_silent) else $error("acknowledge while programming");

   property p_prog_len;
      @(posedge mclk_i) disable iff (rst_i)
      $rose(r.busy) |-> (r.tmr == TMR_W'(PROG_CYCLES - 1)) ##0 r.busy [*8];
   endproperty
   a_prog_len: assert property (p_prog_len) else $error("programming timer wrong");

   property p_wp_block;
      @(posedge mclk_i) disable iff (rst_i)
      (stop_evt && r.wp_s && !r.busy) |=> !r.busy;
   endproperty
   a_wp_block: assert property (p_wp_block) else $error("programming under write protect");

   property p_page_wrap;
      @(posedge mclk_i) disable iff (rst_i)
      (scl_rise && !start_evt && !stop_evt && (r.fsm == sew_pkg::ST_DATA) && (r.bit_cnt == sew_pkg::BIT_LAST)
       && !(r.is_id && r.id_locked)) |=> (r.ofs == OFS_W'($past(r.ofs) + 1)) && (r.row == $past(r.row));
   endproperty
   a_page_wrap: assert property (p_page_wrap) else $error("page offset did not step");

   property p_locked_hold;
      @(posedge mclk_i) disable iff (rst_i)
      ((r.fsm == sew_pkg::ST_DATA) && r.is_id && r.id_locked) |-> !r.ack_req;
   endproperty
   a_locked_hold: assert property (p_locked_hold) else $error("locked page acknowledged");

   property p_nvm_in_cycle;
      @(posedge mclk_i) disable iff (rst_i)
      r.nvm_wr |-> r.busy && !r.prog_lock;
   endproperty
   a_nvm_in_cycle: assert property (p_nvm_in_cycle) else $error("array written outside programming");

   c_prog: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(r.busy));
   c_lock: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(r.id_locked));
   c_wrap: cover property (@(posedge mclk_i) disable iff (rst_i)
                           (r.fsm == sew_pkg::ST_DATA) && (r.ofs == 7'h00) && ($past(r.ofs) == 7'h7F));
   c_ack: cover property (@(negedge scl_i) disable iff (rst_i) $rose(l.drive));

endmodule : sew_eeprom_write_port
`default_nettype wire

// ===== verif/sew_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sew_ctl_model #(
   parameter int Q_NS = 130
) (
   // two-wire link
   output var logic  scl_o,
   output var logic  sda_low_o,
   input  wire logic sda_i
);
   // ****************
   // bus controller
   // ****************
   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic half(input logic s);
      scl_o = s;
      #Q_NS;
   endtask : half
   // fast clocks so the link stage sees reset
   task automatic reset_clocks();
      repeat (4) begin
         scl_o = 1'b0;
         #6;
         scl_o = 1'b1;
         #6;
      end
   endtask : reset_clocks
   task automatic begin_frame();
      sda_low_o = 1'b0;
      #Q_NS;
      half(1'b1);
      sda_low_o = 1'b1;
      #Q_NS;
      half(1'b0);
   endtask : begin_frame
   task automatic end_frame();
      sda_low_o = 1'b1;
      #Q_NS;
      half(1'b1);
      sda_low_o = 1'b0;
      #Q_NS;
   endtask : end_frame
   // up to nine clocks until data reads high, then a start
   task automatic recover();
      for (int i = 0; i < 9; i++) begin
         if (scl_o === 1'b1 && sda_i === 1'b1) break;
         half(1'b0);
         half(1'b1);
      end
      begin_frame();
   endtask : recover
   // data changes only with the clock low
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low_o = ~b[i];
         #Q_NS;
         half(1'b1);
         #Q_NS;
         half(1'b0);
      end
      sda_low_o = 1'b0;
      #Q_NS;
      half(1'b1);
      ack = (sda_i === 1'b0);
      #Q_NS;
      half(1'b0);
   endtask : send_byte
endmodule : sew_ctl_model
`default_nettype wire

// ===== verif/sew_eeprom_write_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sew_eeprom_write_port_tb_top;
   localparam int PROG = 1000;
   logic        mclk_i;
   logic        rst_i;
   logic        scl;
   logic        sda_low;
   logic        sda_i;
   logic [2:0]  straps;
   logic        wp;
   wire logic   sda_oe;
   wire logic   sda_dev;
   wire logic   nvm_wr;
   wire logic   nvm_id;
   wire logic [15:0] nvm_addr;
   wire logic [7:0]  nvm_data;
   wire logic   busy;
   wire logic   standby;
   wire logic   id_locked;
   int          error_cnt = 0;
   int          total_checks = 0;
   logic [24:0] wr_q[$];
   // open-drain wire with pull-up
   assign sda_i = ~sda_low & (sda_oe ? sda_dev : 1'b1);
   sew_eeprom_write_port #(.PROG_CYCLES(PROG)) u_sew_eeprom_write_port (
      .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_dev), .sda_oe_o(sda_oe),
      .chip_select_straps_i(straps), .wp_i(wp), .nvm_wr_o(nvm_wr), .nvm_id_o(nvm_id),
      .nvm_addr_o(nvm_addr), .nvm_data_o(nvm_data), .busy_o(busy), .standby_o(standby),
      .id_locked_o(id_locked));
   sew_ctl_model u_sew_ctl_model (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_i));
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   always @(negedge mclk_i) begin
      if (nvm_wr === 1'b1) wr_q.push_back({nvm_id, nvm_addr, nvm_data});
   end
   // ****************
   // helpers
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic frame(input logic [7:0] dev, input logic [15:0] wa, input int n,
                        input logic [7:0] d0, output int hdr, output int dat);
      logic ack;
      hdr = 0;
      dat = 0;
      u_sew_ctl_model.begin_frame();
      u_sew_ctl_model.send_byte(dev, ack);
      hdr += int'(ack);
      u_sew_ctl_model.send_byte(wa[15:8], ack);
      hdr += int'(ack);
      u_sew_ctl_model.send_byte(wa[7:0], ack);
      hdr += int'(ack);
      for (int i = 0; i < n; i++) begin
         u_sew_ctl_model.send_byte(d0 + 8'(i), ack);
         dat += int'(ack);
      end
      u_sew_ctl_model.end_frame();
   endtask : frame
   // busy cycles seen, 0 if programming never starts
   task automatic wait_prog(output int n);
      int w;
      w = 0;
      n = 0;
      while (busy !== 1'b1 && w < 40) begin
         @(negedge mclk_i);
         w++;
      end
      while (busy === 1'b1 && n < PROG + 20) begin
         @(negedge mclk_i);
         n++;
      end
      @(negedge mclk_i);
   endtask : wait_prog
   task automatic poll(input logic [7:0] dev, output logic ack);
      u_sew_ctl_model.begin_frame();
      u_sew_ctl_model.send_byte(dev, ack);
      u_sew_ctl_model.end_frame();
   endtask : poll
   // ****************
   // scenarios
   // ****************
   task automatic t_byte();
      int hdr, dat, n;
      logic ack;
      @(negedge mclk_i);
      straps = 3'h5;
      wr_q.delete();
      frame(8'hAA, 16'h1234, 1, 8'h5C, hdr, dat);
      check(hdr, 3);
      check(dat, 1);
      poll(8'hAA, ack);
      check({31'h0, ack}, 0);
      wait_prog(n);
      check({31'h0, n > 0 && n <= PROG}, 1);
      check({31'h0, standby}, 1);
      poll(8'hAA, ack);
      check({31'h0, ack}, 1);
      check(wr_q.size(), 1);
      check({7'h0, wr_q[0]}, {7'h0, 1'b0, 16'h1234, 8'h5C});
      $display("test byte_write done");
   endtask : t_byte
   task automatic t_addr();
      int hdr, dat, n;
      logic ack;
      @(negedge mclk_i);
      straps = 3'h0;
      wr_q.delete();
      frame(8'hA0, 16'h0000, 0, 8'h00, hdr, dat);
      check(hdr, 3);
      frame(8'hA2, 16'h0000, 0, 8'h00, hdr, dat);
      check(hdr, 0);
      frame(8'hC0, 16'h0000, 0, 8'h00, hdr, dat);
      check(hdr, 0);
      poll(8'hA1, ack);
      check({31'h0, ack}, 1);
      repeat (10) @(negedge mclk_i);
      check({31'h0, standby}, 1);
      wait_prog(n);
      check(n, 0);
      check(wr_q.size(), 0);
      $display("test addressing done");
   endtask : t_addr
   task automatic t_page();
      int hdr, dat, n, i;
      @(negedge mclk_i);
      straps = 3'h5;
      wr_q.delete();
      frame(8'hAA, {9'h1AB, 7'd126}, 130, 8'h00, hdr, dat);
      check(dat, 130);
      wait_prog(n);
      check(wr_q.size(), 128);
      for (int o = 0; o < 128 && o < wr_q.size(); o++) begin
         i = (o + 2) % 128;
         if (i + 128 < 130) i += 128;
         check({7'h0, wr_q[o]}, {7'h0, 1'b0, 9'h1AB, 7'(o), 8'(i)});
      end
      $display("test page_wrap done");
   endtask : t_page
   task automatic t_wp();
      int hdr, dat, n;
      @(negedge mclk_i);
      wp = 1'b1;
      wr_q.delete();
      frame(8'hAA, 16'h0010, 2, 8'h11, hdr, dat);
      check(dat, 2);
      wait_prog(n);
      check(n, 0);
      check(wr_q.size(), 0);
      @(negedge mclk_i);
      wp = 1'b0;
      $display("test protect done");
   endtask : t_wp
   task automatic t_id();
      int hdr, dat, n;
      wr_q.delete();
      frame(8'hBA, 16'hF3C5, 1, 8'h3E, hdr, dat);
      check(dat, 1);
      wait_prog(n);
      check(wr_q.size(), 1);
      check({7'h0, wr_q[0]}, {7'h0, 1'b1, 16'h0005, 8'h3E});
      frame(8'hBA, 16'h0400, 1, 8'h02, hdr, dat);
      check(dat, 1);
      wait_prog(n);
      check({31'h0, id_locked}, 1);
      frame(8'hBA, 16'h0007, 2, 8'h44, hdr, dat);
      check(hdr, 3);
      check(dat, 0);
      wait_prog(n);
      check(wr_q.size(), 1);
      $display("test id_page done");
   endtask : t_id
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   initial begin
      #1_500_000;
      error_cnt++;
      complete_run();
   end
   initial begin
      rst_i = 1'b1;
      straps = 3'h0;
      wp = 1'b0;
      fork
         u_sew_ctl_model.reset_clocks();
         repeat (3) @(negedge mclk_i);
      join
      rst_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      check({28'h0, standby, busy, id_locked, nvm_wr}, 32'h8);
      u_sew_ctl_model.recover();
      u_sew_ctl_model.end_frame();
      t_byte();
      t_addr();
      t_page();
      t_wp();
      t_id();
      complete_run();
   end
endmodule : sew_eeprom_write_port_tb_top
`default_nettype wire
